// file: tcp_pin_model.sv
// tcp_pin_model: far side of the count path, pin driver and comparator result
// assumes lvl is called just after a rising clock edge
module tcp_pin_model (
  // clock
  input  wire logic hclk,
  // pin from the block
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // toward the block
  output logic      pin_in,
  output logic      cmp_raw
);
  logic drv_ff;
  // the block owns the wire while enabled, its output then feeds back
  assign pin_in = pin_oe ? pin_out : drv_ff;
  initial begin
    drv_ff  = 1'b0;
    cmp_raw = 1'b0;
  end
  // each level held 8 clocks, well above two phases and the latency
  task automatic lvl(input logic use_cmp, input logic v);
    if (use_cmp) cmp_raw <= v;
    else drv_ff <= v;
    repeat (8) @(posedge hclk);
  endtask : lvl
endmodule : tcp_pin_model

// file: tcp_pkg.sv
// tcp_pkg: register map, field positions, reset values and timing for the timer/prescaler block
// assumes a 32-bit ahb-lite bus with one register per aligned word
package tcp_pkg;
  // register byte offsets
  localparam logic [7:0] TCP_OFF_COUNT  = 8'h04;  // timer_count, index 01h
  localparam logic [7:0] TCP_OFF_CMP    = 8'h1C;  // comparator_control, index 07h
  localparam logic [7:0] TCP_OFF_CFG    = 8'h20;
  localparam logic [7:0] TCP_OFF_DIR    = 8'h24;
  localparam logic [7:0] TCP_OFF_CMD    = 8'h28;
  localparam logic [7:0] TCP_OFF_STAT   = 8'h2C;
  // timer_config_reg fields
  localparam int TCP_CFG_CSS = 5;
  localparam int TCP_CFG_SES = 4;
  localparam int TCP_CFG_PSA = 3;
  // comparator_control fields
  localparam int TCP_CMP_OUT = 7;
  localparam int TCP_CMP_POD = 6;
  localparam int TCP_CMP_POL = 5;
  localparam int TCP_CMP_CCR = 4;
  localparam int TCP_CMP_ON  = 3;
  // command register bit
  localparam int TCP_CMD_WDCLR = 0;
  // reset values
  localparam logic [7:0] TCP_CFG_RST   = 8'hFF;
  localparam logic [6:0] TCP_CMP_RST   = 7'h7F;
  localparam logic [3:0] TCP_DIR_RST   = 4'hF;
  localparam logic [7:0] TCP_COUNT_RST = 8'h00;
  localparam logic [7:0] TCP_PS_RST    = 8'h00;
  // count pin position within pin_direction
  localparam int TCP_PIN_BIT = 2;
  // write inhibit after a timer_count write
  localparam logic [1:0] TCP_INHIBIT_CYC = 2'd2;
  // prescaler width: the shared 8-bit prescaler
  localparam int TCP_PS_W = 8;
endpackage : tcp_pkg

// file: tcp_prescaler.sv
// tcp_prescaler: 8-bit prescaler counter shared between timer and watchdog
// assumes inc is a one-cycle pulse per source event and clr is synchronous
module tcp_prescaler
  import tcp_pkg::*;
#(
  parameter int W = TCP_PS_W
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // control
  input  wire logic         inc,
  input  wire logic         clr,
  input  wire logic [2:0]   ratio,
  // output
  output logic              tick
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         tick_ff;

  // divide by 2^(ratio+1): tap bit ratio of the count, pulse on its fall
  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr) begin
      nxt_cnt = TCP_PS_RST[W-1:0];
    end else if (inc) begin
      nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= TCP_PS_RST[W-1:0];
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_ff <= 1'b0;
    end else begin
      // tap bit falls once per 2^(ratio+1) events, giving a symmetric divider
      tick_ff <= !clr && inc && cnt_ff[ratio] && (nxt_cnt[ratio] == 1'b0);
    end
  end

  assign tick = tick_ff;
endmodule : tcp_prescaler

// file: tcp_timer.sv
// tcp_timer: 8-bit timer/counter with shared prescaler, behind an ahb-lite slave
// assumes ext pin and comparator inputs are synchronous to hclk (one hclk = one phase)
module tcp_timer
  import tcp_pkg::*;
(
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // instruction cycle strobe and comparator result
  input  wire logic        instr_cycle,
  input  wire logic        comparator_raw,
  // count pin, three-signal
  input  wire logic        ext_count_pin_in,
  output logic             ext_count_pin_out,
  output logic             ext_count_pin_oe,
  // watchdog side
  output logic             watchdog_clear,
  output logic             watchdog_tick
);
  // register state
  logic [7:0]  count_ff;
  logic [7:0]  nxt_count;
  logic [7:0]  cfg_ff;
  logic [6:0]  cmp_ff;
  logic [3:0]  dir_ff;
  logic [1:0]  inhibit_ff;
  logic [1:0]  nxt_inhibit;
  // bus data phase
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_rdata;
  // source sampling, one flop per phase
  logic        src_q2_ff;
  logic        src_q4_ff;
  // watchdog side and pin
  logic        wdclr_ff;
  logic        wdtick_ff;
  logic        pin_out_ff;
  logic        pin_oe_ff;
  logic        nxt_pin_oe;
  // bus decode
  logic        addr_phase;
  logic        addr_ok;
  logic        word_xfer;
  logic        rd_req;
  logic        count_wr;
  logic        cfg_wr;
  logic        cmp_wr;
  logic        dir_wr;
  logic        wdclr_wr;
  // control fields
  logic        css;
  logic        ses;
  logic        cmp_on;
  logic        route_cfg;
  logic        pin_off;
  // count path
  logic        cmp_out;
  logic        sel_pin;
  logic        src_lvl;
  logic        src_edge;
  logic        ps_to_timer;
  logic        ps_inc;
  logic        ps_clr;
  logic        ps_tick;
  logic        count_inc;
  logic        inhibit_busy;

  // one compare per register word, shared by write strobes and the map check
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // offsets that raise a pending write, the status word included though nothing stores it; anything else is ignored
  function automatic logic is_mapped(input logic [7:0] a);
    return hit(a, TCP_OFF_COUNT) || hit(a, TCP_OFF_CMP) || hit(a, TCP_OFF_CFG) ||
           hit(a, TCP_OFF_DIR) || hit(a, TCP_OFF_CMD) || hit(a, TCP_OFF_STAT);
  endfunction : is_mapped

  // edge of the sampled source; fall picks the falling edge
  function automatic logic edge_of(input logic now, input logic old, input logic fall);
    return fall ? (old && !now) : (!old && now);
  endfunction : edge_of

  // zero wait states: an address phase is taken the edge it is seen
  assign addr_phase = hsel && hready && htrans[1];
  assign addr_ok    = haddr[31:8] == 24'h000000;
  // only whole-word writes are decoded; narrower writes are dropped
  assign word_xfer  = hsize == 3'b010;
  assign rd_req     = addr_phase && !hwrite;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= addr_phase && hwrite && addr_ok && word_xfer && is_mapped(haddr[7:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_ff <= 8'h00;
    end else if (addr_phase) begin
      wr_addr_ff <= haddr[7:0];
    end
  end

  // write data is taken in the data phase, one edge after the address
  assign count_wr = wr_pend_ff && hit(wr_addr_ff, TCP_OFF_COUNT);
  assign cfg_wr   = wr_pend_ff && hit(wr_addr_ff, TCP_OFF_CFG);
  assign cmp_wr   = wr_pend_ff && hit(wr_addr_ff, TCP_OFF_CMP);
  assign dir_wr   = wr_pend_ff && hit(wr_addr_ff, TCP_OFF_DIR);
  assign wdclr_wr = wr_pend_ff && hit(wr_addr_ff, TCP_OFF_CMD) && hwdata[TCP_CMD_WDCLR];

  // configuration registers, one process each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= TCP_CFG_RST;
    end else if (cfg_wr) begin
      cfg_ff <= hwdata[7:0];
    end
  end

  // bit 7 of the comparator word is the live result, so it is not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_ff <= TCP_CMP_RST;
    end else if (cmp_wr) begin
      cmp_ff <= hwdata[6:0];
    end
  end

  // only the count pin's direction bit matters to this block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_ff <= TCP_DIR_RST;
    end else if (dir_wr) begin
      dir_ff <= hwdata[3:0];
    end
  end

  assign css       = cfg_ff[TCP_CFG_CSS];
  assign ses       = cfg_ff[TCP_CFG_SES];
  assign cmp_on    = cmp_ff[TCP_CMP_ON];
  assign route_cfg = cmp_ff[TCP_CMP_CCR];
  assign pin_off   = cmp_ff[TCP_CMP_POD];

  // comparator result with polarity; off reads as low
  assign cmp_out = cmp_on && (comparator_raw ~^ cmp_ff[TCP_CMP_POL]);

  // pin only when the route bit is set; with the comparator on and the disable
  // bit clear the comparator drives the pin and its input stays live, so it feeds back
  assign sel_pin = route_cfg;
  assign src_lvl = sel_pin ? ext_count_pin_in : cmp_out;

  // one hclk stands for one phase: q2 then q4
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q2_ff <= 1'b0;
    end else begin
      src_q2_ff <= src_lvl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q4_ff <= 1'b0;
    end else begin
      src_q4_ff <= src_q2_ff;
    end
  end

  assign src_edge = edge_of(src_q2_ff, src_q4_ff, ses);

  // one shared prescaler: the timer or the watchdog, never both
  assign ps_to_timer = !cfg_ff[TCP_CFG_PSA];
  assign ps_inc      = (ps_to_timer && css) ? src_edge : instr_cycle;
  assign ps_clr      = (ps_to_timer && count_wr) || (!ps_to_timer && wdclr_wr);

  // prescaler count has no bus path
  tcp_prescaler #(.W(TCP_PS_W)) u_ps (
    .hclk    (hclk),
    .hresetn (hresetn),
    .inc     (ps_inc),
    .clr     (ps_clr),
    .ratio   (cfg_ff[2:0]),
    .tick    (ps_tick)
  );

  // without the prescaler the source feeds the count directly
  assign count_inc = ps_to_timer ? ps_tick : (css ? src_edge : instr_cycle);

  // write inhibit, measured in instruction cycles; software adjusts the
  // written value to make up for the two lost counts
  assign inhibit_busy = inhibit_ff != 2'd0;

  always_comb begin
    nxt_inhibit = inhibit_ff;
    if (count_wr) begin
      nxt_inhibit = TCP_INHIBIT_CYC;
    end else if (instr_cycle && inhibit_busy) begin
      nxt_inhibit = inhibit_ff - 2'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inhibit_ff <= 2'd0;
    end else begin
      inhibit_ff <= nxt_inhibit;
    end
  end

  // a bus write wins over an increment in the same cycle
  always_comb begin
    nxt_count = count_ff;
    if (count_wr) begin
      nxt_count = hwdata[7:0];
    end else if (count_inc && !inhibit_busy) begin
      nxt_count = count_ff + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= TCP_COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // watchdog pulses: clear command, and a prescaled or raw tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdclr_ff <= 1'b0;
    end else begin
      wdclr_ff <= wdclr_wr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdtick_ff <= 1'b0;
    end else begin
      wdtick_ff <= ps_to_timer ? instr_cycle : ps_tick;
    end
  end

  assign watchdog_clear = wdclr_ff;
  assign watchdog_tick  = wdtick_ff;

  // source select takes the pin's direction; otherwise the comparator or
  // the direction register decides
  always_comb begin
    nxt_pin_oe = !dir_ff[TCP_PIN_BIT];
    if (css) begin
      nxt_pin_oe = cmp_on && !pin_off && route_cfg;
    end else if (cmp_on) begin
      nxt_pin_oe = !pin_off;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_ff <= 1'b0;
    end else begin
      pin_out_ff <= cmp_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_oe_ff <= 1'b0;
    end else begin
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign ext_count_pin_out = pin_out_ff;
  assign ext_count_pin_oe  = pin_oe_ff;

  // read word chosen in the address phase so hrdata comes from a flop;
  // the prescaler count has no entry in this map
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (addr_ok) begin
      unique case (haddr[7:0])
        TCP_OFF_COUNT: nxt_rdata = {24'h000000, count_ff};
        TCP_OFF_CMP:   nxt_rdata = {24'h000000, cmp_out, cmp_ff};
        TCP_OFF_CFG:   nxt_rdata = {24'h000000, cfg_ff};
        TCP_OFF_DIR:   nxt_rdata = {28'h0000000, dir_ff};
        TCP_OFF_STAT:  nxt_rdata = {30'h00000000, src_q4_ff, inhibit_busy};
        default:       nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_req) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // no wait states and no error answers
  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule : tcp_timer

// file: tcp_timer_chk.sv
// tcp_timer_chk: bus answer and watchdog-side properties of tcp_timer
// assumes it is bound to tcp_timer and sees only that module's ports
module tcp_timer_chk
  import tcp_pkg::*;
(
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // watchdog side
  input wire logic        instr_cycle,
  input wire logic        watchdog_clear,
  input wire logic        watchdog_tick
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic ap;
  logic cfg_wr_ff;
  logic psa_ff;
  assign ap = hsel && hready && htrans[1];
  // shadow of the assign bit, so tick checks skip the switch-over cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_wr_ff <= 1'b0;
      psa_ff    <= 1'b1;
    end else begin
      cfg_wr_ff <= ap && hwrite && haddr == {24'h0, TCP_OFF_CFG};
      if (cfg_wr_ff) psa_ff <= hwdata[TCP_CFG_PSA];
    end
  end
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not okay");
  a_unmapped_zero: assert property (ap && !hwrite && haddr == 32'h30 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_count_width: assert property (ap && !hwrite && haddr == {24'h0, TCP_OFF_COUNT}
    |=> hrdata[31:8] == 24'h0) else $error("count read wider than 8 bits");
  a_stat_width: assert property (ap && !hwrite && haddr == {24'h0, TCP_OFF_STAT}
    |=> hrdata[31:2] == 30'h0) else $error("status exposes more bits");
  a_wdclr_soon: assert property (ap && hwrite && haddr == {24'h0, TCP_OFF_CMD}
    ##1 hwdata[TCP_CMD_WDCLR] |-> ##[0:2] watchdog_clear) else $error("no watchdog clear");
  a_wdclr_single: assert property (watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");
  a_tick_follows: assert property (!psa_ff && !cfg_wr_ff
    |=> watchdog_tick == $past(instr_cycle)) else $error("watchdog tick not undivided");
  a_tick_divided: assert property ((psa_ff && !cfg_wr_ff) [*3] ##0 watchdog_tick
    |=> !watchdog_tick) else $error("watchdog tick not divided");
endmodule : tcp_timer_chk

bind tcp_timer tcp_timer_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .instr_cycle, .watchdog_clear, .watchdog_tick);

// file: tcp_timer_tb.sv
// tcp_timer_tb: register, timer, prescaler and counter-mode scenarios
// assumes tcp_timer with its bound checker and the pin model
module tcp_timer_tb
  import tcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
  logic        instr_cycle, cmp_raw, pin_in, pin_out, pin_oe, wd_clr, wd_tick;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          mismatches, checks;
  assign hready = hreadyout;
  tcp_timer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .instr_cycle(instr_cycle),
    .comparator_raw(cmp_raw), .ext_count_pin_in(pin_in), .ext_count_pin_out(pin_out),
    .ext_count_pin_oe(pin_oe), .watchdog_clear(wd_clr), .watchdog_tick(wd_tick));
  tcp_pin_model pin (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .cmp_raw(cmp_raw));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic report_and_stop;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      mismatches++;
      $display("unexpected %0t bus hang", $time);
      report_and_stop();
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc
  task automatic ic(input int n);
    repeat (n) begin
      instr_cycle <= 1'b1;
      @(posedge hclk);
      instr_cycle <= 1'b0;
      @(posedge hclk);
    end
  endtask : ic
  task automatic t_regs;
    rdc(TCP_OFF_COUNT, 32'hFFFFFFFF, {24'h0, TCP_COUNT_RST});
    rdc(TCP_OFF_CMP, 32'h7F, {25'h0, TCP_CMP_RST});
    xfer(1'b1, 8'h30, 32'hFFFFFFFF);
    rdc(8'h30, 32'hFFFFFFFF, 32'h0);
  endtask : t_regs
  task automatic t_timer;
    xfer(1'b1, TCP_OFF_CFG, 32'hC8);
    xfer(1'b1, TCP_OFF_COUNT, 32'h10);
    rdc(TCP_OFF_COUNT, 32'hFFFFFFFF, 32'h10);
    ic(5);
    rdc(TCP_OFF_COUNT, 32'hFF, 32'h13);
    ic(4);
    rdc(TCP_OFF_COUNT, 32'hFF, 32'h17);
    xfer(1'b1, TCP_OFF_COUNT, 32'hFF);
    ic(3);
    rdc(TCP_OFF_COUNT, 32'hFF, 32'h00);
    xfer(1'b1, TCP_OFF_CMD, 32'h1);
    ic(4);
  endtask : t_timer
  task automatic t_prescale;
    for (int r = 0; r < 8; r++) begin
      xfer(1'b1, TCP_OFF_CFG, 32'hC0 + r);
      // a stray event first; an uncleared prescaler would still leave the count at 3
      ic(1);
      xfer(1'b1, TCP_OFF_COUNT, 32'h0);
      ic(1 + (3 << (r + 1)));
      rdc(TCP_OFF_COUNT, 32'hFF, 32'h3);
    end
  endtask : t_prescale
  task automatic t_count;
    logic [7:0] cf [4] = '{8'hE8, 8'hF8, 8'hE8, 8'hE8};
    logic [7:0] cm [4] = '{8'h7F, 8'h7F, 8'h3F, 8'h2F};
    logic [7:0] ex [4] = '{8'h04, 8'h03, 8'h04, 8'h04};
    instr_cycle <= 1'b1;
    xfer(1'b1, TCP_OFF_DIR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, TCP_OFF_CFG, {24'h0, cf[i]});
      xfer(1'b1, TCP_OFF_CMP, {24'h0, cm[i]});
      pin.lvl(i > 1, 1'b0);
      xfer(1'b1, TCP_OFF_COUNT, 32'h0);
      pin.lvl(i > 1, 1'b0);
      repeat (3) begin
        pin.lvl(i > 1, 1'b1);
        pin.lvl(i > 1, 1'b0);
      end
      pin.lvl(i > 1, 1'b1);
      rdc(TCP_OFF_COUNT, 32'hFF, {24'h0, ex[i]});
      chk({31'h0, pin_oe}, 32'(i == 2));
    end
    instr_cycle <= 1'b0;
  endtask : t_count
  task automatic t_switch;
    logic [7:0] base;
    int         n;
    n = 0;
    xfer(1'b1, TCP_OFF_CMD, 32'h1);
    @(negedge hclk);
    chk({31'h0, wd_clr}, 32'h1);
    @(posedge hclk);
    xfer(1'b1, TCP_OFF_COUNT, 32'h0);
    xfer(1'b1, TCP_OFF_CFG, 32'hC8);
    repeat (8) begin
      instr_cycle <= 1'b1;
      @(posedge hclk);
      instr_cycle <= 1'b0;
      @(posedge hclk);
      @(negedge hclk);
      n += int'(wd_tick);
      @(posedge hclk);
    end
    chk(32'(n), 32'd4);
    // leave the watchdog prescaler part-way so only a clear hides it
    ic(2);
    xfer(1'b0, TCP_OFF_COUNT, 32'h0);
    base = rd[7:0];
    xfer(1'b1, TCP_OFF_CMD, 32'h1);
    xfer(1'b1, TCP_OFF_CFG, 32'hC1);
    ic(3);
    rdc(TCP_OFF_COUNT, 32'hFF, {24'h0, base});
  endtask : t_switch
  initial begin
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    instr_cycle = 1'b0;
    mismatches  = 0;
    checks      = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_timer();
    t_prescale();
    t_switch();
    t_count();
    report_and_stop();
  end
endmodule : tcp_timer_tb
